// *** dv/hsa_hue_sat_adjuster_tb.sv ***
// Purpose: Self-checking bench for the hue and saturation adjuster
// Assumes: 100 MHz clock, APB master tasks, pixel source model
// Notes: Expected pixels are queued and compared in order once each stream drains
`timescale 1ns/1ns
`include "hsa_consts.vh"
module hsa_hue_sat_adjuster_tb;
  logic clk = 1'b0;
  logic rstN = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat, r;
  logic pready, pslverr, err, pixInValid, pixOutValid;
  logic [7:0] pixInR, pixInG, pixInB, pixOutR, pixOutG, pixOutB;
  logic [23:0] o, p, expQ[$], gotQ[$];
  logic [7:0] hv[6] = '{8'h80, 8'h7F, 8'hDC, 8'h00, 8'h01, 8'hFF}; // Hue boundaries
  logic [7:0] sv[6] = '{8'h00, 8'hFF, 8'hB0, 8'h80, 8'h01, 8'h7F}; // Gain boundaries
  logic [7:0] ctl[5] = '{8'h00, 8'h02, 8'h03, 8'h07, 8'h01}; // Control cases
  int miscompares = 0, n_compared = 0, i;
  always #5 clk = ~clk;
  hsa_hue_sat_adjuster u_hsa_hue_sat_adjuster (.clk(clk), .rst_n(rstN), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixInValid(pixInValid), .pixInR(pixInR), .pixInG(pixInG), .pixInB(pixInB), .pixOutValid(pixOutValid),
    .pixOutR(pixOutR), .pixOutG(pixOutG), .pixOutB(pixOutB));
  hsa_pix_src u_hsa_pix_src (.clk(clk), .pixInValid(pixInValid), .pixInR(pixInR), .pixInG(pixInG),
    .pixInB(pixInB));
  // Downstream capture of every output pixel
  always @(posedge clk) if (pixOutValid === 1'b1) gotQ.push_back({pixOutR, pixOutG, pixOutB});
  // ----------------------------------------
  // Compare and bus tasks
  // ----------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chkPix(input logic [23:0] g, input logic [23:0] e);
    chk({8'h0, g}, {8'h0, e});
  endtask
  task chkFlag(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  // APB: setup, access, hold until ready sampled high
  // A slave that never answers is caught by the watchdog
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // One pixel through, result returned
  task px(input logic [23:0] q, output logic [23:0] res);
    u_hsa_pix_src.put(q);
    u_hsa_pix_src.idle();
    repeat (6) @(posedge clk);
    chk(32'(gotQ.size()), 32'h1);
    res = gotQ.size() ? gotQ.pop_front() : 24'h0;
  endtask
  // Back-to-back random stream expected unchanged
  task strm(input logic gray);
    for (int k = 0; k < 40; k++) begin
      r = $urandom;
      p = gray ? {3{r[7:0]}} : r[23:0];
      expQ.push_back(p);
      u_hsa_pix_src.put(p);
    end
    u_hsa_pix_src.idle();
    repeat (6) @(posedge clk);
    chk(32'(gotQ.size()), 32'd40);
    while (gotQ.size() && expQ.size()) chkPix(gotQ.pop_front(), expQ.pop_front());
    expQ.delete();
  endtask
  task close_out();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    r = $urandom(99);
    repeat (3) @(posedge clk);
    rstN <= 1'b1;
    rd(`HSA_OFS_CTRL, 32'h0);
    rd(`HSA_OFS_HUE, 32'h0);
    rd(`HSA_OFS_SAT, 32'h80);
    rd(`HSA_OFS_STATUS, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chkFlag(err, 1'b1);
    apb(1'b1, `HSA_OFS_STATUS, 32'hFFFFFFFF);
    chkFlag(err, 1'b0);
    $display("registers reset done");
    for (i = 0; i < 6; i++) begin
      r = $urandom;
      apb(1'b1, `HSA_OFS_CTRL, {25'h0, i[2:0], 4'h1});
      apb(1'b1, `HSA_OFS_HUE, {r[31:8], hv[i]});
      apb(1'b1, `HSA_OFS_SAT, {24'h0, sv[i]});
    end
    for (i = 0; i < 6; i++) begin
      apb(1'b1, `HSA_OFS_CTRL, {25'h0, i[2:0], 4'h1});
      rd(`HSA_OFS_HUE, {{24{hv[i][7]}}, hv[i]});
      rd(`HSA_OFS_SAT, {24'h0, sv[i]});
    end
    $display("sector table done");
    strm(1'b1);
    for (i = 0; i < 6; i++) begin
      apb(1'b1, `HSA_OFS_CTRL, {25'h0, i[2:0], 4'h1});
      apb(1'b1, `HSA_OFS_HUE, 32'h0);
      apb(1'b1, `HSA_OFS_SAT, {24'h0, `HSA_SAT_UNITY});
    end
    strm(1'b0);
    $display("streams done");
    apb(1'b1, `HSA_OFS_CTRL, 32'h1);
    apb(1'b1, `HSA_OFS_SAT, 32'h0);
    for (i = 0; i < 5; i++) begin
      apb(1'b1, `HSA_OFS_CTRL, {24'h0, ctl[i]});
      apb(1'b0, `HSA_OFS_STATUS, 32'h0);
      chkFlag(rdat[0], ctl[i][0] && (ctl[i][2] || !ctl[i][1]));
      px(24'hC82828, o);
      // Gain zero: gray level (200+40)/2 = 120
      chkPix(o, (ctl[i][0] && (ctl[i][2] || !ctl[i][1])) ? 24'h787878 : 24'hC82828);
    end
    px(24'h00FF00, o);
    chkPix(o, 24'h00FF00);
    px(24'hFF8000, o);
    chkFlag(o != 24'hFF8000 && o[23:16] != o[15:8], 1'b1);
    px(24'hFF0080, o);
    chkFlag(o != 24'hFF0080 && o[23:16] != o[7:0], 1'b1);
    $display("control and neighbours done");
    apb(1'b1, `HSA_OFS_SAT, 32'h80);
    apb(1'b1, `HSA_OFS_HUE, 32'h80);
    px(24'hFF0000, o);
    chkPix(o, 24'hFFFF00);
    apb(1'b1, `HSA_OFS_HUE, 32'h7F);
    px(24'hFF0000, o);
    chkFlag(o[23:16] == 8'hFF && o[15:8] == 8'h00 && o[7:0] >= 8'hF0, 1'b1);
    apb(1'b1, `HSA_OFS_HUE, 32'h0);
    apb(1'b1, `HSA_OFS_SAT, 32'hFF);
    px(24'h963232, o);
    chkFlag(int'(o[23:16]) - int'(o[15:8]) > 100, 1'b1);
    // Seven colour pixels met non-neutral settings while active; none in flight
    rd(`HSA_OFS_STATUS, 32'h00070001);
    $display("rotation and gain done");
    close_out();
  end
endmodule // hsa_hue_sat_adjuster_tb

// *** dv/hsa_hue_sat_chk.sv ***
// Purpose: Port-level checks for the hue and saturation adjuster
// Assumes: One clock; rst_n async, active low
// Notes: Keeps a shadow of the control bits seen on APB writes
`timescale 1ns/1ns
`include "hsa_consts.vh"
module hsa_hue_sat_chk (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire pixInValid,
  input wire [7:0] pixInR,
  input wire [7:0] pixInG,
  input wire [7:0] pixInB,
  input wire pixOutValid,
  input wire [7:0] pixOutR,
  input wire [7:0] pixOutG,
  input wire [7:0] pixOutB
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  reg [2:0] ctrlReg; // Enable, Bayer out, permit
  wire mapped = paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0;
  wire active = ctrlReg[0] && !(ctrlReg[1] && !ctrlReg[2]);
  wire [23:0] pixIn = {pixInR, pixInG, pixInB};
  wire [23:0] pixOut = {pixOutR, pixOutG, pixOutB};
  // Shadow updates on the completing write edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlReg <= 3'h0;
    end else if (psel && penable && pready && pwrite && paddr == `HSA_OFS_CTRL) begin
      ctrlReg <= pwdata[2:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_wait_state: assert property (psel && penable && !pready |=> pready) else $error("no ready after wait");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
  a_err_decode: assert property (pready |-> pslverr == !mapped) else $error("error flag wrong");
  a_err_nodata: assert property (pready && (pwrite || pslverr) |-> prdata == 32'h0) else $error("read data not zero");
  a_hue_sext: assert property (pready && !pwrite && paddr == `HSA_OFS_HUE |->
    prdata[31:8] == {24{prdata[7]}}) else $error("hue not sign extended");
  a_sat_unsigned: assert property (pready && !pwrite && paddr == `HSA_OFS_SAT |->
    prdata[31:8] == 24'h0) else $error("gain upper bits set");
  a_pix_latency: assert property (pixInValid |-> ##4 pixOutValid) else $error("pixel lost");
  a_pix_origin: assert property (pixOutValid |-> $past(pixInValid, 4)) else $error("spurious pixel");
  a_bypass_idle: assert property (pixInValid && !active |-> ##4 pixOut == $past(pixIn, 4))
    else $error("inactive pixel altered");
  a_gray_pass: assert property (pixInValid && pixInR == pixInG && pixInG == pixInB |->
    ##4 pixOut == $past(pixIn, 4)) else $error("gray pixel altered");
endmodule // hsa_hue_sat_chk

bind hsa_hue_sat_adjuster hsa_hue_sat_chk u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pixInValid(pixInValid), .pixInR(pixInR), .pixInG(pixInG), .pixInB(pixInB), .pixOutValid(pixOutValid),
  .pixOutR(pixOutR), .pixOutG(pixOutG), .pixOutB(pixOutB));

// *** dv/hsa_pix_src.sv ***
// Purpose: Upstream pixel source model
// Assumes: Caller steps one pixel per put
// Notes: Data lines invert once on release and then hold while no pixel is offered
`timescale 1ns/1ns
module hsa_pix_src (
  input wire clk,
  output logic pixInValid,
  output logic [7:0] pixInR,
  output logic [7:0] pixInG,
  output logic [7:0] pixInB
);
  // Idle lines at time zero
  initial begin
    pixInValid = 1'b0;
    {pixInR, pixInG, pixInB} = 24'h5A5A5A;
  end
  // Offer one pixel for one edge
  task put(input logic [23:0] p);
    @(posedge clk);
    pixInValid <= 1'b1;
    {pixInR, pixInG, pixInB} <= p;
  endtask
  // Release; inverted data so stale values never pass for valid
  task idle();
    @(posedge clk);
    pixInValid <= 1'b0;
    {pixInR, pixInG, pixInB} <= ~{pixInR, pixInG, pixInB};
  endtask
endmodule // hsa_pix_src

// *** hdl/hsa_consts.vh ***
// Purpose: Constants shared by the hue and saturation adjuster files
// Assumes: 32-bit APB data, 12-bit byte address, 8-bit RGB pixels
// Notes: Definitions only
`ifndef HSA_CONSTS_VH
`define HSA_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define HSA_OFS_CTRL 12'h000
`define HSA_OFS_HUE 12'h004
`define HSA_OFS_SAT 12'h008
`define HSA_OFS_STATUS 12'h00C

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define HSA_CTRL_ENABLE 0
`define HSA_CTRL_BAYER_OUT 1
`define HSA_CTRL_BAYER_PERMIT 2
`define HSA_CTRL_PICK_LSB 4
`define HSA_CTRL_PICK_MSB 6

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define HSA_STAT_ACTIVE 0
`define HSA_STAT_BUSY 1
`define HSA_STAT_COUNT_LSB 16

// ----------------------------------------
// Reset values and scale points
// ----------------------------------------
`define HSA_CTRL_RESET 7'h00
`define HSA_HUE_RESET 8'h00
`define HSA_SAT_RESET 8'h80
`define HSA_SAT_UNITY 8'h80
`define HSA_CNT_RESET 16'h0000

// ----------------------------------------
// Hexagon geometry (hue in 1/256 sector units)
// ----------------------------------------
`define HSA_SECTORS 6
`define HSA_SECT_SPAN 12'h100
`define HSA_HUE_FULL 12'h600
`define HSA_SECT_RED 3'h0
`define HSA_SECT_YELLOW 3'h1
`define HSA_SECT_GREEN 3'h2
`define HSA_SECT_CYAN 3'h3
`define HSA_SECT_BLUE 3'h4
`define HSA_SECT_MAGENTA 3'h5

// ----------------------------------------
// Pipeline latency in clock cycles
// ----------------------------------------
`define HSA_LATENCY 4

`endif

// *** hdl/hsa_hue_sat_adjuster.v ***
// Purpose: Per-pixel hue rotation and saturation scaling over six hexagon sectors
// Assumes: RGB pixels already white balanced; APB slave for settings
// Notes: Four-cycle pipeline; one wait state on every APB access
`timescale 1ns/1ns
`include "hsa_consts.vh"

module hsa_hue_sat_adjuster (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire pixInValid,
  input wire [7:0] pixInR,
  input wire [7:0] pixInG,
  input wire [7:0] pixInB,
  output reg pixOutValid,
  output reg [7:0] pixOutR,
  output reg [7:0] pixOutG,
  output reg [7:0] pixOutB
);

  // ----------------------------------------
  // Control and status registers
  // ----------------------------------------
  reg [6:0] ctrl_reg; // Enable, Bayer flags, sector pick
  reg [15:0] count_reg; // Adjusted pixel count, wraps
  wire adjustOn = ctrl_reg[`HSA_CTRL_ENABLE];
  wire bayerOut = ctrl_reg[`HSA_CTRL_BAYER_OUT];
  wire bayerPermit = ctrl_reg[`HSA_CTRL_BAYER_PERMIT];
  wire [2:0] sectorPick = ctrl_reg[`HSA_CTRL_PICK_MSB:`HSA_CTRL_PICK_LSB];
  wire active = adjustOn && !(bayerOut && !bayerPermit);

  // ----------------------------------------
  // APB access decode
  // ----------------------------------------
  wire accessDone = psel && penable && pready; // Last access cycle
  wire wrDone = accessDone && pwrite;
  wire hitCtrl = (paddr == `HSA_OFS_CTRL);
  wire hitHue = (paddr == `HSA_OFS_HUE);
  wire hitSat = (paddr == `HSA_OFS_SAT);
  wire hitStat = (paddr == `HSA_OFS_STATUS);
  wire hitAny = hitCtrl || hitHue || hitSat || hitStat;
  wire [15:0] pickData; // Selected sector entry
  reg busy; // Any pixel in flight

  // Ready after one wait state, data and error with it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        pslverr <= !hitAny;
        if (pwrite || !hitAny) begin
          prdata <= 32'h00000000;
        end else if (hitCtrl) begin
          prdata <= {25'h0000000, ctrl_reg};
        end else if (hitHue) begin
          prdata <= {{24{pickData[15]}}, pickData[15:8]};
        end else if (hitSat) begin
          prdata <= {24'h000000, pickData[7:0]};
        end else begin
          prdata <= {count_reg, 14'h0000, busy, active};
        end
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Control register write
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `HSA_CTRL_RESET;
    end else if (wrDone && hitCtrl) begin
      ctrl_reg <= pwdata[6:0];
    end
  end

  // ----------------------------------------
  // Stage 1: input capture
  // ----------------------------------------
  reg v1; // Stage 1 valid
  reg [7:0] r1, g1, b1; // Stage 1 pixel
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      v1 <= 1'b0;
      r1 <= 8'h00;
      g1 <= 8'h00;
      b1 <= 8'h00;
    end else begin
      v1 <= pixInValid;
      r1 <= pixInR;
      g1 <= pixInG;
      b1 <= pixInB;
    end
  end

  // ----------------------------------------
  // Hexagon position of the stage 1 pixel
  // ----------------------------------------
  reg [2:0] region; // Ordering of components
  reg [7:0] mx, md, mn; // Max, middle, min
  always @* begin
    region = `HSA_SECT_MAGENTA;
    mx = r1;
    md = b1;
    mn = g1;
    if (r1 >= g1 && g1 >= b1) begin
      region = `HSA_SECT_RED;
      mx = r1; md = g1; mn = b1;
    end else if (g1 > r1 && r1 >= b1) begin
      region = `HSA_SECT_YELLOW;
      mx = g1; md = r1; mn = b1;
    end else if (g1 >= b1 && b1 > r1) begin
      region = `HSA_SECT_GREEN;
      mx = g1; md = b1; mn = r1;
    end else if (b1 > g1 && g1 > r1) begin
      region = `HSA_SECT_CYAN;
      mx = b1; md = g1; mn = r1;
    end else if (b1 >= r1 && r1 > g1) begin
      region = `HSA_SECT_BLUE;
      mx = b1; md = r1; mn = g1;
    end
  end

  wire [7:0] chroma = mx - mn; // Colourfulness
  wire [15:0] fracNum = {md - mn, 8'h00}; // Scaled mid offset
  wire [15:0] fracQ = (chroma == 8'h00) ? 16'h0000 : fracNum / {8'h00, chroma};
  wire [11:0] regBase = {1'b0, region, 8'h00}; // Region start
  wire [11:0] fracW = {3'b000, fracQ[8:0]}; // 0..256
  wire [11:0] hueRaw = region[0] ? (regBase + `HSA_SECT_SPAN - fracW) : (regBase + fracW);
  wire [11:0] hueNow = (hueRaw >= `HSA_HUE_FULL) ? (hueRaw - `HSA_HUE_FULL) : hueRaw;
  wire [2:0] vertA = hueNow[10:8]; // Sector at or below hue
  wire [2:0] vertB = (vertA == `HSA_SECT_MAGENTA) ? `HSA_SECT_RED : (vertA + 3'h1);

  // ----------------------------------------
  // Sector table
  // ----------------------------------------
  wire [15:0] entA, entB; // Bracketing sector entries
  hsa_sector_table #(
    .ENTRIES(`HSA_SECTORS)
  ) uTable (
    .clk(clk),
    .rst_n(rst_n),
    .wrAddr(sectorPick),
    .wrHueEn(wrDone && hitHue),
    .wrSatEn(wrDone && hitSat),
    .wrData(pwdata[7:0]),
    .rdAddrA(vertA),
    .rdAddrB(vertB),
    .rdAddrC(sectorPick),
    .rdDataA(entA),
    .rdDataB(entB),
    .rdDataC(pickData)
  );

  // ----------------------------------------
  // Stage 2: hue position registered
  // ----------------------------------------
  reg v2; // Stage 2 valid
  reg [23:0] pix2; // Original pixel
  reg [11:0] h2; // Hue position
  reg [7:0] c2; // Chroma
  reg [8:0] l2; // Max plus min
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      v2 <= 1'b0;
      pix2 <= 24'h000000;
      h2 <= 12'h000;
      c2 <= 8'h00;
      l2 <= 9'h000;
    end else begin
      v2 <= v1;
      pix2 <= {r1, g1, b1};
      h2 <= hueNow;
      c2 <= chroma;
      l2 <= {1'b0, mx} + {1'b0, mn};
    end
  end

  // ----------------------------------------
  // Blend of the two bracketing sectors
  // ----------------------------------------
  wire [8:0] wB = {1'b0, h2[7:0]}; // Weight of upper sector
  wire [8:0] wA = 9'h100 - wB; // Weight of lower sector
  // raw hue is signed, 128 per sector (2 hue units per step)
  // raw span gives full real range
  wire signed [18:0] hueMix = $signed(entA[15:8]) * $signed({1'b0, wA})
                            + $signed(entB[15:8]) * $signed({1'b0, wB});
  wire signed [10:0] dh = hueMix[18:8]; // Blended shift, -128..127
  // raw span gives full real range
  wire [16:0] satMix = entA[7:0] * wA + entB[7:0] * wB;
  wire [7:0] gain = satMix[15:8]; // Blended gain
  wire signed [12:0] hueShift = $signed({1'b0, h2}) - $signed({dh, 1'b0});
  wire signed [12:0] hueFull = $signed({1'b0, `HSA_HUE_FULL});
  wire signed [12:0] hueWrap = (hueShift < 13'sd0) ? (hueShift + hueFull)
                             : (hueShift >= hueFull) ? (hueShift - hueFull) : hueShift;
  wire [15:0] chromaProd = c2 * gain;
  wire [8:0] chromaNew = chromaProd[15:7];
  wire ident = !active || (c2 == 8'h00) || (dh == 11'sd0 && gain == `HSA_SAT_UNITY);

  // ----------------------------------------
  // Stage 3: adjusted hue and chroma
  // ----------------------------------------
  reg v3; // Stage 3 valid
  reg [23:0] pix3; // Original pixel
  reg [11:0] h3; // New hue position
  reg [8:0] c3; // New chroma
  reg [8:0] l3; // Max plus min
  reg id3; // Pass unchanged
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      v3 <= 1'b0;
      pix3 <= 24'h000000;
      h3 <= 12'h000;
      c3 <= 9'h000;
      l3 <= 9'h000;
      id3 <= 1'b1;
    end else begin
      v3 <= v2;
      pix3 <= pix2;
      h3 <= hueWrap[11:0];
      c3 <= chromaNew;
      l3 <= l2;
      id3 <= ident;
    end
  end

  // Adjusted pixel counter and busy flag
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= `HSA_CNT_RESET;
      busy <= 1'b0;
    end else begin
      busy <= pixInValid || v1 || v2 || v3;
      if (v2 && !ident) begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Rebuild RGB around the gray level
  // ----------------------------------------
  wire [9:0] hiSum = {1'b0, l3} + {1'b0, c3};
  wire signed [10:0] loSum = $signed({2'b00, l3}) - $signed({2'b00, c3});
  wire [7:0] hiV = (hiSum[9:1] > 9'h0FF) ? 8'hFF : hiSum[8:1];
  wire [7:0] loV = (loSum < 11'sd0) ? 8'h00 : loSum[8:1];
  wire [7:0] cEff = hiV - loV; // Chroma after clamping
  wire [8:0] tW = {1'b0, h3[7:0]};
  wire [8:0] dW = h3[8] ? (9'h100 - tW) : tW; // Mid fraction, odd regions mirror
  wire [16:0] midProd = dW * cEff;
  wire [7:0] midV = loV + midProd[15:8];
  reg [23:0] rebuilt; // Reassembled pixel
  // region table mirrors the hexagon order
  always @* begin
    case (h3[10:8])
      `HSA_SECT_RED: rebuilt = {hiV, midV, loV};
      `HSA_SECT_YELLOW: rebuilt = {midV, hiV, loV};
      `HSA_SECT_GREEN: rebuilt = {loV, hiV, midV};
      `HSA_SECT_CYAN: rebuilt = {loV, midV, hiV};
      `HSA_SECT_BLUE: rebuilt = {midV, loV, hiV};
      `HSA_SECT_MAGENTA: rebuilt = {hiV, loV, midV};
      default: rebuilt = pix3;
    endcase
  end

  // ----------------------------------------
  // Stage 4: output registers
  // ----------------------------------------
  // bypass path keeps pixel
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pixOutValid <= 1'b0;
      pixOutR <= 8'h00;
      pixOutG <= 8'h00;
      pixOutB <= 8'h00;
    end else begin
      pixOutValid <= v3;
      if (id3) begin
        {pixOutR, pixOutG, pixOutB} <= pix3;
      end else begin
        {pixOutR, pixOutG, pixOutB} <= rebuilt;
      end
    end
  end

endmodule // hsa_hue_sat_adjuster

// *** hdl/hsa_sector_table.v ***
// Purpose: Six-entry table of per-sector hue shift and saturation gain
// Assumes: One write port, three registered read ports
// Notes: Entry is {hue[7:0], sat[7:0]}; read data lag address by one cycle
`timescale 1ns/1ns
`include "hsa_consts.vh"

module hsa_sector_table #(
  parameter ENTRIES = `HSA_SECTORS
) (
  input wire clk,
  input wire rst_n,
  input wire [2:0] wrAddr,
  input wire wrHueEn,
  input wire wrSatEn,
  input wire [7:0] wrData,
  input wire [2:0] rdAddrA,
  input wire [2:0] rdAddrB,
  input wire [2:0] rdAddrC,
  output reg [15:0] rdDataA,
  output reg [15:0] rdDataB,
  output reg [15:0] rdDataC
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  wire [15:0] entryFlat [0:7]; // Entry contents, unused slots read neutral

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : gEntry
      if (gi < ENTRIES) begin : gLive
        reg [7:0] hue_reg; // Signed hue shift
        reg [7:0] sat_reg; // Unsigned saturation gain
        // One stored value per sector and per setting
        always @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            hue_reg <= `HSA_HUE_RESET;
            sat_reg <= `HSA_SAT_RESET;
          end else begin
            if (wrHueEn && wrAddr == gi) begin
              hue_reg <= wrData;
            end
            if (wrSatEn && wrAddr == gi) begin
              sat_reg <= wrData;
            end
          end
        end
        assign entryFlat[gi] = {hue_reg, sat_reg};
      end else begin : gNone
        assign entryFlat[gi] = {`HSA_HUE_RESET, `HSA_SAT_RESET};
      end
    end
  endgenerate

  // ----------------------------------------
  // Registered read ports
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdDataA <= {`HSA_HUE_RESET, `HSA_SAT_RESET};
      rdDataB <= {`HSA_HUE_RESET, `HSA_SAT_RESET};
      rdDataC <= {`HSA_HUE_RESET, `HSA_SAT_RESET};
    end else begin
      rdDataA <= entryFlat[rdAddrA];
      rdDataB <= entryFlat[rdAddrB];
      rdDataC <= entryFlat[rdAddrC];
    end
  end

endmodule // hsa_sector_table
